// File: design/host_access_map.svh
`ifndef HOST_ACCESS_MAP_SVH
`define HOST_ACCESS_MAP_SVH
// ----------------------------------------------------------------------------
// Register offsets (per link X at X*0x100; SW_RESET_OFF is one global address)
// ----------------------------------------------------------------------------
`define SW_RESET_OFF 10'h004
`define LINE_MODE_OFF 8'h20
`define TX_CFG0_OFF 8'h22
`define RX_CFG0_OFF 8'h28
`define TXP_STAT_OFF 8'hC8
`define TXP_CTRL_OFF 8'hC9
`define TXP_DATA_OFF 8'hCA
`define RXP_STAT_OFF 8'hCD
`define RXP_CTRL_OFF 8'hCE
`define RXP_DATA_OFF 8'hCF
`define RXS_STAT_OFF 8'hD3
`define RXS_CTRL_OFF 8'hD4
`define RXS_DATA_OFF 8'hD5
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define POWER_OFF_BIT 4
`define BUSY_BIT 0
`define DIR_BIT 7
`define REG_RESET_VAL 8'h00
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define ACCESS_WAIT_MS 2
`define ACCESS_WAIT_CYC (`ACCESS_WAIT_MS * 1000000 / `CLK_PERIOD_NS)
`define POWERUP_RESET_MS 10
`define POWERUP_RESET_CYC (`POWERUP_RESET_MS * 1000000 / `CLK_PERIOD_NS)
`define HW_RESET_NS 100
`define HW_RESET_CYC ((`HW_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INDIRECT_NS 4000
`define INDIRECT_CYC (`INDIRECT_NS / `CLK_PERIOD_NS)
`define INDIRECT_WORK_CYC 8'h20
`define SCLK_HALF_CYC 4
`endif

// File: design/host_access_pkg.sv
package host_access_pkg;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_CMD = 2'b01,
    SER_DATA = 2'b10,
    SER_DONE = 2'b11
  } ser_state_t;
  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_SHIFT = 2'b01,
    HST_END = 2'b10
  } host_state_t;
endpackage

// File: design/host_link_if.sv
interface host_link_if;
  logic reset_n;
  logic serial_host_select;
  logic bus_style_select;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic ds_rd_n;
  logic rw_wr_n;
  logic [9:0] addr;
  logic [7:0] data_to_dev;
  logic [7:0] data_from_dev;
  logic data_oe;
  modport dev (
    input reset_n, serial_host_select, bus_style_select, cs_n, sclk, sdi,
    ds_rd_n, rw_wr_n, addr, data_to_dev,
    output sdo, sdo_oe, data_from_dev, data_oe
  );
  modport host (
    output reset_n, serial_host_select, bus_style_select, cs_n, sclk, sdi,
    ds_rd_n, rw_wr_n, addr, data_to_dev,
    input sdo, sdo_oe, data_from_dev, data_oe
  );
endinterface

// File: design/indirect_port.sv
`include "host_access_map.svh"
// One indirect access engine; the per-channel store lives here.
module indirect_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_val,
  input wire logic data_wr,
  input wire logic [7:0] data_val,
  output logic busy,
  output logic [7:0] data_reg
);
  logic [7:0] mem [0:127];
  logic [7:0] count_reg;
  logic dir_reg;
  logic [6:0] addr_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
      count_reg <= 8'h00;
      dir_reg <= 1'b0;
      addr_reg <= 7'h00;
    end else if (ce) begin
      if (ctrl_wr && !busy) begin
        busy <= 1'b1;
        dir_reg <= ctrl_val[`DIR_BIT];
        addr_reg <= ctrl_val[6:0];
        count_reg <= `INDIRECT_WORK_CYC;
      end else if (busy) begin
        if (count_reg == 8'h00) begin
          busy <= 1'b0;
        end else begin
          count_reg <= count_reg - 8'h01;
        end
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_reg <= `REG_RESET_VAL;
    end else if (ce) begin
      if (busy && count_reg == 8'h00 && dir_reg) begin
        data_reg <= mem[addr_reg];
      end else if (data_wr && !busy) begin
        data_reg <= data_val;
      end
    end
  end
  // The store is not cleared by reset; like real RAM it holds its contents.
  always_ff @(posedge ref_clk) begin
    if (ce && busy && count_reg == 8'h00 && !dir_reg) begin
      mem[addr_reg] <= data_reg;
    end
  end
endmodule // indirect_port

// File: design/transceiver_access.sv
`include "host_access_map.svh"
// Notes on behaviour
// - Host holds reset low 10 ms at power-up.
// - Defaults loaded; access allowed after 2 ms.
// - Runtime hardware reset pulse at least 100 ns.
// - Software reset clears all but line mode; the indirect stores are not cleared.
// - Line mode register cleared only by hardware reset.
// - Host issues software reset after line-mode change.
// - Receive power-down holds receive output low.
// - Transmit power-down floats transmit output.
// - Serial select high: serial; low: parallel.
// - Chip select frames each serial transaction.
// - Two header bytes: command, address, sampled rising.
// - Command bit one reads, zero writes.
// - Read data shifts out on falling clock.
// - Write data byte follows address byte.
// - Bus style pin picks strobe scheme.
// - Address and data buses are separate.
// - Per-channel registers reached only indirectly.
// - Indirect read: check busy, control, busy, data.
// - Indirect write: check busy, data, control.
// - Indirect access completes within 4 us.
module transceiver_access #(
  parameter int WAIT_CYC = `ACCESS_WAIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  host_link_if.dev link,
  input wire logic [3:0] rx_line_data,
  input wire logic [3:0] tx_line_data,
  output logic [3:0] rx_out,
  output logic [3:0] tx_out,
  output logic [3:0] tx_out_oe,
  output logic ready
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [7:0] sync1_reg, sync2_reg, prev_reg;
  logic [9:0] addr_s1_reg, addr_s2_reg;
  logic [7:0] wd_s1_reg, wd_s2_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 8'hFF;
      sync2_reg <= 8'hFF;
      prev_reg <= 8'hFF;
      addr_s1_reg <= 10'h000;
      addr_s2_reg <= 10'h000;
      wd_s1_reg <= 8'h00;
      wd_s2_reg <= 8'h00;
    end else if (ce) begin
      addr_s1_reg <= link.addr;
      addr_s2_reg <= addr_s1_reg;
      wd_s1_reg <= link.data_to_dev;
      wd_s2_reg <= wd_s1_reg;
      sync1_reg <= {link.reset_n, link.serial_host_select, link.bus_style_select,
                    link.cs_n, link.sclk, link.sdi, link.ds_rd_n, link.rw_wr_n};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  logic pin_rst_n, ser_mode, style, cs_n, sclk, sdi, strb_n, rw_n;
  assign {pin_rst_n, ser_mode, style, cs_n, sclk, sdi, strb_n, rw_n} = sync2_reg;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign sclk_rise = sclk && !prev_reg[3];
  assign sclk_fall = !sclk && prev_reg[3];
  assign cs_fall = !cs_n && prev_reg[4];
  assign cs_rise = cs_n && !prev_reg[4];
  // --------------------------------------------------------------------------
  // Reset and access-wait
  // --------------------------------------------------------------------------
  logic hw_rst, sw_rst;
  logic [31:0] wait_reg;
  assign hw_rst = rst || !pin_rst_n;
  always_ff @(posedge ref_clk) begin
    if (hw_rst) begin
      wait_reg <= 32'(WAIT_CYC);
    end else if (ce) begin
      if (sw_rst) begin
        wait_reg <= 32'(WAIT_CYC);
      end else if (wait_reg != 32'h0) begin
        wait_reg <= wait_reg - 32'h1;
      end
    end
  end
  assign ready = (wait_reg == 32'h0);
  // --------------------------------------------------------------------------
  // Unified access strobes from either host interface
  // --------------------------------------------------------------------------
  logic acc_wr, acc_rd;
  logic [9:0] acc_addr;
  logic [7:0] acc_wdata, rdata;
  // Parallel: style low is strobe plus read/write, high is split strobes.
  logic strobe_fall, par_wr, par_rd;
  assign strobe_fall = !strb_n && prev_reg[1] && !cs_n;
  assign par_wr = !ser_mode && (style ? (!rw_n && prev_reg[0] && !cs_n)
                                      : (strobe_fall && !rw_n));
  assign par_rd = !ser_mode && strobe_fall && (style || rw_n);
  // Serial engine.
  host_access_pkg::ser_state_t st_reg;
  logic [3:0] bit_reg;
  logic [15:0] hdr_reg;
  logic [7:0] sh_reg;
  logic ser_wr, ser_rd;
  always_ff @(posedge ref_clk) begin
    if (hw_rst) begin
      st_reg <= host_access_pkg::SER_IDLE;
      bit_reg <= 4'h0;
      hdr_reg <= 16'h0000;
      sh_reg <= 8'h00;
    end else if (ce) begin
      if (!ser_mode || cs_rise) begin
        st_reg <= host_access_pkg::SER_IDLE;
      end else begin
        unique case (st_reg)
          host_access_pkg::SER_IDLE: begin
            if (cs_fall) begin
              st_reg <= host_access_pkg::SER_CMD;
              bit_reg <= 4'h0;
            end
          end
          host_access_pkg::SER_CMD: begin
            if (sclk_rise) begin
              hdr_reg <= {hdr_reg[14:0], sdi};
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'hF) begin
                st_reg <= host_access_pkg::SER_DATA;
              end
            end
          end
          host_access_pkg::SER_DATA: begin
            if (sclk_rise && !hdr_reg[15]) begin
              sh_reg <= {sh_reg[6:0], sdi};
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'h7) begin
                st_reg <= host_access_pkg::SER_DONE;
              end
            end else if (read_loaded_reg) begin
              sh_reg <= rdata;
            end else if (sclk_fall && hdr_reg[15]) begin
              sh_reg <= {sh_reg[6:0], 1'b0};
            end
          end
          host_access_pkg::SER_DONE: begin
            st_reg <= host_access_pkg::SER_DONE;
          end
        endcase
      end
    end
  end
  logic read_loaded_reg;
  always_ff @(posedge ref_clk) begin
    if (hw_rst) begin
      read_loaded_reg <= 1'b0;
    end else if (ce) begin
      read_loaded_reg <= ser_rd;
    end
  end
  assign ser_wr = ser_mode && st_reg == host_access_pkg::SER_DATA && sclk_rise
                  && !hdr_reg[15] && bit_reg == 4'h7;
  // The read fires as the header completes; data appears one cycle later.
  assign ser_rd = ser_mode && st_reg == host_access_pkg::SER_CMD && sclk_rise
                  && bit_reg == 4'hF && hdr_reg[14];
  assign acc_wr = ready && (ser_mode ? ser_wr : par_wr);
  assign acc_rd = ready && (ser_mode ? ser_rd : par_rd);
  // A read is taken before the last header bit is shifted in, so it comes from sdi.
  assign acc_addr = ser_mode ? (ser_rd ? {hdr_reg[8:0], sdi} : hdr_reg[9:0])
                             : addr_s2_reg;
  assign acc_wdata = ser_mode ? {sh_reg[6:0], sdi} : wd_s2_reg;
  // --------------------------------------------------------------------------
  // Register file, per link
  // --------------------------------------------------------------------------
  logic [7:0] mode_reg [4];
  logic [7:0] txc_reg [4];
  logic [7:0] rxc_reg [4];
  logic [7:0] ind_data [4][3];
  logic ind_busy [4][3];
  function automatic logic [1:0] ind_sel(input logic [7:0] off);
    unique case (off)
      `TXP_STAT_OFF, `TXP_CTRL_OFF, `TXP_DATA_OFF: ind_sel = 2'd0;
      `RXP_STAT_OFF, `RXP_CTRL_OFF, `RXP_DATA_OFF: ind_sel = 2'd1;
      `RXS_STAT_OFF, `RXS_CTRL_OFF, `RXS_DATA_OFF: ind_sel = 2'd2;
      default: ind_sel = 2'd3;
    endcase
  endfunction
  function automatic logic [1:0] ind_kind(input logic [7:0] off);
    unique case (off)
      `TXP_CTRL_OFF, `RXP_CTRL_OFF, `RXS_CTRL_OFF: ind_kind = 2'd1;
      `TXP_DATA_OFF, `RXP_DATA_OFF, `RXS_DATA_OFF: ind_kind = 2'd2;
      default: ind_kind = 2'd0;
    endcase
  endfunction
  assign sw_rst = acc_wr && acc_addr == `SW_RESET_OFF;
  logic [1:0] lnk;
  logic [7:0] off;
  assign lnk = acc_addr[9:8];
  assign off = acc_addr[7:0];
  genvar g, b;
  generate
    for (g = 0; g < 4; g++) begin : g_link
      logic hit;
      assign hit = acc_wr && lnk == 2'(g);
      always_ff @(posedge ref_clk) begin
        if (hw_rst) begin
          mode_reg[g] <= `REG_RESET_VAL;
        end else if (ce && hit && off == `LINE_MODE_OFF) begin
          mode_reg[g] <= acc_wdata;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (hw_rst || (ce && sw_rst)) begin
          txc_reg[g] <= `REG_RESET_VAL;
          rxc_reg[g] <= `REG_RESET_VAL;
        end else if (ce && hit && off == `TX_CFG0_OFF) begin
          txc_reg[g] <= acc_wdata;
        end else if (ce && hit && off == `RX_CFG0_OFF) begin
          rxc_reg[g] <= acc_wdata;
        end
      end
      assign rx_out[g] = rxc_reg[g][`POWER_OFF_BIT] ? 1'b0 : rx_line_data[g];
      assign tx_out[g] = tx_line_data[g];
      assign tx_out_oe[g] = !txc_reg[g][`POWER_OFF_BIT];
      for (b = 0; b < 3; b++) begin : g_blk
        logic hit_blk;
        assign hit_blk = hit && ind_sel(off) == 2'(b);
        indirect_port u_port (
          .ref_clk(ref_clk),
          .rst(hw_rst || sw_rst),
          .ce(ce),
          .ctrl_wr(hit_blk && ind_kind(off) == 2'd1),
          .ctrl_val(acc_wdata),
          .data_wr(hit_blk && ind_kind(off) == 2'd2),
          .data_val(acc_wdata),
          .busy(ind_busy[g][b]),
          .data_reg(ind_data[g][b])
        );
      end
    end
  endgenerate
  // --------------------------------------------------------------------------
  // Read data, registered one cycle after the access
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (hw_rst) begin
      rdata <= 8'h00;
    end else if (ce && acc_rd) begin
      if (off == `LINE_MODE_OFF) begin
        rdata <= mode_reg[lnk];
      end else if (off == `TX_CFG0_OFF) begin
        rdata <= txc_reg[lnk];
      end else if (off == `RX_CFG0_OFF) begin
        rdata <= rxc_reg[lnk];
      end else if (ind_sel(off) != 2'd3 && ind_kind(off) == 2'd0) begin
        rdata <= {7'h00, ind_busy[lnk][ind_sel(off)]};
      end else if (ind_sel(off) != 2'd3 && ind_kind(off) == 2'd2) begin
        rdata <= ind_data[lnk][ind_sel(off)];
      end else begin
        rdata <= 8'h00;
      end
    end
  end
  logic par_oe_reg;
  always_ff @(posedge ref_clk) begin
    if (hw_rst) begin
      par_oe_reg <= 1'b0;
    end else if (ce) begin
      par_oe_reg <= !ser_mode && !cs_n && (style ? !strb_n : (!strb_n && rw_n));
    end
  end
  assign link.data_from_dev = rdata;
  assign link.data_oe = par_oe_reg;
  // Serial read data is first valid once loaded; MSB out first.
  assign link.sdo = read_loaded_reg ? rdata[7] : sh_reg[7];
  assign link.sdo_oe = ser_mode && st_reg == host_access_pkg::SER_DATA && hdr_reg[15];
endmodule // transceiver_access

// File: design/host_controller.sv
`include "host_access_map.svh"
// Serial host end: user issues one read or write, the engine drives the pins.
module host_controller (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  host_link_if.host link,
  input wire logic dev_reset_n,
  input wire logic req_wr,
  input wire logic req_rd,
  input wire logic [9:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic [7:0] rd_data,
  output logic done
);
  host_access_pkg::host_state_t st_reg;
  logic [23:0] sh_reg;
  logic [4:0] bits_reg;
  logic [2:0] div_reg;
  logic sclk_reg, cs_reg, is_rd_reg, sdo_s1, sdo_s2;
  logic [7:0] rx_reg;
  assign link.reset_n = dev_reset_n;
  assign link.serial_host_select = 1'b1;
  assign link.bus_style_select = 1'b0;
  assign link.ds_rd_n = 1'b1;
  assign link.rw_wr_n = 1'b1;
  assign link.addr = 10'h000;
  assign link.data_to_dev = 8'h00;
  assign link.cs_n = cs_reg;
  assign link.sclk = sclk_reg;
  assign link.sdi = sh_reg[23];
  assign busy = st_reg != host_access_pkg::HST_IDLE;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sdo_s1 <= 1'b0;
      sdo_s2 <= 1'b0;
    end else if (ce) begin
      sdo_s1 <= link.sdo;
      sdo_s2 <= sdo_s1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= host_access_pkg::HST_IDLE;
      sh_reg <= 24'h000000;
      bits_reg <= 5'h00;
      div_reg <= 3'h0;
      sclk_reg <= 1'b0;
      cs_reg <= 1'b1;
      is_rd_reg <= 1'b0;
      rx_reg <= 8'h00;
      rd_data <= 8'h00;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      unique case (st_reg)
        host_access_pkg::HST_IDLE: begin
          if (req_wr || req_rd) begin
            cs_reg <= 1'b0;
            // Command bit, then address, then data or idle bits.
            sh_reg <= {req_rd, 5'h00, req_addr, req_wdata};
            is_rd_reg <= req_rd;
            bits_reg <= 5'h00;
            div_reg <= 3'h0;
            st_reg <= host_access_pkg::HST_SHIFT;
          end
        end
        host_access_pkg::HST_SHIFT: begin
          if (div_reg == 3'(`SCLK_HALF_CYC - 1)) begin
            div_reg <= 3'h0;
            sclk_reg <= !sclk_reg;
            if (sclk_reg) begin
              sh_reg <= {sh_reg[22:0], 1'b0};
              bits_reg <= bits_reg + 5'h01;
              if (bits_reg == 5'd23) begin
                st_reg <= host_access_pkg::HST_END;
              end
            end else if (bits_reg >= 5'd16) begin
              rx_reg <= {rx_reg[6:0], sdo_s2};
            end
          end else begin
            div_reg <= div_reg + 3'h1;
          end
        end
        host_access_pkg::HST_END: begin
          cs_reg <= 1'b1;
          if (is_rd_reg) begin
            rd_data <= rx_reg;
          end
          done <= 1'b1;
          st_reg <= host_access_pkg::HST_IDLE;
        end
        default: st_reg <= host_access_pkg::HST_IDLE;
      endcase
    end
  end
endmodule // host_controller

// File: dv/host_register_access_port_chk.sv
module host_register_access_port_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_host_select,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] edges_reg;
  logic sclk_reg;
  logic cmd_reg;
  logic oe_seen_reg;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // --------------------------------------------------------------------------
  // Frame tracking
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    sclk_reg <= sclk;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || cs_n) begin
      edges_reg <= 5'h00;
    end else if (sclk && !sclk_reg) begin
      edges_reg <= edges_reg + 5'h01;
    end
  end
  // The first rising edge of a frame carries the command bit.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_reg <= 1'b0;
    end else if (!cs_n && sclk && !sclk_reg && edges_reg == 5'h00) begin
      cmd_reg <= sdi;
    end
  end
  // Cleared at frame start, so a late release from the last frame is forgotten.
  always_ff @(posedge ref_clk) begin
    if (rst || (!cs_n && edges_reg == 5'h00)) begin
      oe_seen_reg <= 1'b0;
    end else if (sdo_oe) begin
      oe_seen_reg <= 1'b1;
    end
  end
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  AST_CLOCK_IN_FRAME: assert property (cs_n |-> !sclk)
    else $error("serial clock moved outside a frame");
  AST_SCLK_HIGH_HOLD: assert property ($rose(sclk) |=> sclk [*3] ##1 !sclk)
    else $error("serial clock high phase has the wrong length");
  AST_SDI_STABLE: assert property (sclk && sclk_reg |-> $stable(sdi))
    else $error("serial input changed while the clock was high");
  AST_FRAME_BITS: assert property ($rose(cs_n) |-> edges_reg == 5'h18)
    else $error("frame did not carry 24 clock edges");
  AST_WRITE_NO_DRIVE: assert property (!cs_n && edges_reg > 5'h01 && !cmd_reg |-> !sdo_oe)
    else $error("serial output driven during a write");
  AST_READ_DRIVES: assert property ($rose(cs_n) && cmd_reg |-> oe_seen_reg)
    else $error("serial output never driven during a read");
  AST_SDO_HOLD_RISE: assert property ($rose(sclk) && sdo_oe |=> $stable(sdo) [*3])
    else $error("serial output changed around a rising clock edge");
  AST_PARALLEL_QUIET: assert property (serial_host_select [*4] |-> !data_oe)
    else $error("parallel data bus driven in serial mode");
  AST_IDLE_RELEASE: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("serial output still driven while deselected");
endmodule // host_register_access_port_chk

// File: dv/host_register_access_port_test.sv
module host_register_access_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  // A short access wait keeps the run brief; a write fits inside it twice.
  localparam int WAIT = 400;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
    logic [3:0] rx_exp;
    logic [3:0] oe_exp;
  } row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic dev_reset_n = 1'b0;
  logic req_wr = 1'b0;
  logic req_rd = 1'b0;
  logic [9:0] req_addr = 10'h000;
  logic [7:0] req_wdata = 8'h00;
  logic [3:0] rx_line_data = 4'hF;
  logic [3:0] tx_line_data = 4'hF;
  logic [3:0] rx_out;
  logic [3:0] tx_out;
  logic [3:0] tx_out_oe;
  logic ready;
  logic busy;
  logic done;
  logic [7:0] rd_data;
  int errors = 0;
  int comparisons = 0;
  int n;
  row_t rows [6] = '{'{10'h020, 8'h5A, 4'hF, 4'hF}, '{10'h122, 8'h10, 4'hF, 4'hD},
    '{10'h228, 8'h10, 4'hB, 4'hD}, '{10'h328, 8'hEF, 4'hB, 4'hD},
    '{10'h022, 8'h11, 4'hB, 4'hC}, '{10'h128, 8'h10, 4'h9, 4'hC}};
  logic [9:0] bases [3] = '{10'h0C8, 10'h0CD, 10'h0D3};

  always #12.5 ref_clk = ~ref_clk;

  host_link_if u_host_link_if ();
  transceiver_access #(.WAIT_CYC(WAIT)) u_transceiver_access (
    .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .link(u_host_link_if),
    .rx_line_data(rx_line_data), .tx_line_data(tx_line_data), .rx_out(rx_out),
    .tx_out(tx_out), .tx_out_oe(tx_out_oe), .ready(ready));
  host_controller u_host_controller (
    .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .link(u_host_link_if),
    .dev_reset_n(dev_reset_n), .req_wr(req_wr), .req_rd(req_rd), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .rd_data(rd_data), .done(done));
  host_register_access_port_chk u_host_register_access_port_chk (
    .ref_clk(ref_clk), .rst(rst), .serial_host_select(u_host_link_if.serial_host_select),
    .cs_n(u_host_link_if.cs_n), .sclk(u_host_link_if.sclk), .sdi(u_host_link_if.sdi),
    .sdo(u_host_link_if.sdo), .sdo_oe(u_host_link_if.sdo_oe),
    .data_oe(u_host_link_if.data_oe));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int k;
    @(posedge ref_clk);
    req_wr <= wr;
    req_rd <= !wr;
    req_addr <= a;
    req_wdata <= d;
    @(posedge ref_clk);
    req_wr <= 1'b0;
    req_rd <= 1'b0;
    for (k = 0; k < 600 && done !== 1'b1; k++) @(posedge ref_clk);
    if (k == 600) begin
      errors++;
      close_out();
    end
  endtask

  task automatic rd_check(input logic [9:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    check(rd_data, e);
  endtask

  task automatic busy_clear(input logic [9:0] a);
    access(1'b0, a, 8'h00);
    check({7'h00, rd_data[0]}, 8'h00);
  endtask

  // Returns the cycles spent so callers can judge how long the level took.
  task automatic wait_ready(input logic lvl, input int bound, output int used);
    for (used = 0; used < bound && ready !== lvl; used++) @(posedge ref_clk);
    if (used == bound) begin
      errors++;
      close_out();
    end
  endtask

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    dev_reset_n <= 1'b1;
    @(posedge ref_clk);
    check({7'h00, ready}, 8'h00);
    wait_ready(1'b1, WAIT + 20, n);
    check(8'(n >= WAIT - 8), 8'h01);
    foreach (rows[i]) begin
      access(1'b1, rows[i].addr, rows[i].data);
      rd_check(rows[i].addr, rows[i].data);
      check({4'h0, rx_out}, {4'h0, rows[i].rx_exp});
      check({4'h0, tx_out_oe}, {4'h0, rows[i].oe_exp});
    end
    access(1'b1, 10'h011, 8'hFF);
    rd_check(10'h020, 8'h5A);
    access(1'b1, 10'h004, 8'hA5);
    wait_ready(1'b0, 20, n);
    // Issued while the device is still settling, so it must be dropped.
    access(1'b1, 10'h022, 8'h10);
    wait_ready(1'b1, WAIT + 20, n);
    rd_check(10'h020, 8'h5A);
    rd_check(10'h122, 8'h00);
    rd_check(10'h022, 8'h00);
    check({rx_out, tx_out_oe}, 8'hFF);
    check({4'h0, tx_out}, 8'h0F);
    @(posedge ref_clk);
    dev_reset_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    dev_reset_n <= 1'b1;
    wait_ready(1'b0, 20, n);
    wait_ready(1'b1, WAIT + 20, n);
    rd_check(10'h020, 8'h00);
    rd_check(10'h128, 8'h00);
    check({4'h0, rx_out}, 8'h0F);
    for (int i = 0; i < 3; i++) begin
      busy_clear(bases[i]);
      access(1'b1, bases[i] + 10'h002, 8'h3C + 8'(i));
      access(1'b1, bases[i] + 10'h001, 8'h05);
      busy_clear(bases[i]);
      access(1'b1, bases[i] + 10'h002, 8'h00);
      access(1'b1, bases[i] + 10'h001, 8'h85);
      busy_clear(bases[i]);
      rd_check(bases[i] + 10'h002, 8'h3C + 8'(i));
    end
    close_out();
  end
endmodule // host_register_access_port_test
